//--- shared/ctl_req_pkg.sv
// constants, field positions and state types for the endpoint-zero request engine
// assumes one 200 MHz clock shared by the usb engine and this block
package ctl_req_pkg;

  localparam logic [7:0] RT_VENDOR_OUT = 8'h40;
  localparam logic [7:0] RT_VENDOR_IN = 8'hc0;
  localparam logic [7:0] RT_CLASS_OUT = 8'h21;
  localparam logic [7:0] RT_CLASS_IN = 8'ha1;
  localparam logic [7:0] RT_DEV_IN = 8'h80;

  localparam logic [7:0] REQ_GET_STATUS = 8'h00;
  localparam logic [7:0] REQ_SET_REG = 8'h00;
  localparam logic [7:0] REQ_GET_REG = 8'h01;
  localparam logic [7:0] REQ_SET_LINE = 8'h20;
  localparam logic [7:0] REQ_GET_LINE = 8'h21;
  localparam logic [7:0] REQ_SET_CTRL = 8'h22;
  localparam logic [7:0] REQ_BREAK = 8'h23;

  localparam logic [7:0] BLK_UART = 8'h00;
  localparam logic [7:0] BLK_MGR = 8'h04;
  localparam logic [7:0] BLK_EEPROM = 8'h65;
  localparam logic [7:0] BLK_CUSTOM = 8'h66;

  localparam logic [7:0] MGR_ENABLE_OFS = 8'h10;
  localparam logic [7:0] MGR_RXFLUSH_OFS = 8'h18;
  localparam logic [7:0] MGR_TXFLUSH_OFS = 8'h1c;
  localparam int MGR_TX_BIT = 0;
  localparam int MGR_RX_BIT = 1;
  localparam logic [1:0] MGR_ENABLE_RST = 2'h0;

  localparam logic [7:0] CUST_WIDE_OFS = 8'h00;
  localparam logic [7:0] CUST_LOWLAT_OFS = 8'h01;
  localparam logic [7:0] CUST_INTPKT_OFS = 8'h02;

  localparam int UART_REG_COUNT = 32;
  localparam logic [7:0] UART_ENABLE_OFS = 8'h03;
  localparam logic [7:0] UART_REG_RST = 8'h00;

  localparam int LINE_BYTES = 7;
  localparam logic [15:0] LINE_CODING_LEN = 16'h0007;
  localparam logic [15:0] STATUS_LEN = 16'h0002;
  // 115200 baud, one stop bit, no parity, eight data bits
  localparam logic [55:0] LINE_CODING_RST = 56'h08_00_00_00_01_c2_00;

  localparam int CTRL_DTR_BIT = 0;
  localparam int CTRL_RTS_BIT = 1;

  localparam logic [15:0] BREAK_FOREVER = 16'hffff;
  localparam int CLK_MHZ = 200;
  localparam int BREAK_UNIT_US = 1000;
  localparam int BREAK_UNIT_CYCLES = BREAK_UNIT_US * CLK_MHZ;

  typedef enum logic [2:0] {
    ST_IDLE, ST_LINE_OUT, ST_FETCH, ST_EE_WAIT, ST_SEND, ST_EE_WRITE
  } ctl_state_t;

  typedef enum logic [1:0] {SRC_REG, SRC_LINE, SRC_STAT} in_src_t;

endpackage : ctl_req_pkg

//--- hw/queue_manager.sv
// queue manager register block: queue enables and flush strobes
// assumes writes arrive as single-cycle strobes from the request engine
`timescale 1ns/1ps
module queue_manager
  import ctl_req_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic wr_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  output logic tx_fifo_en,
  output logic rx_fifo_en,
  output logic rx_flush,
  output logic tx_flush
);

  logic [1:0] enable_q;
  logic rx_flush_q;
  logic tx_flush_q;

  // enable bits, cleared at reset
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      enable_q <= MGR_ENABLE_RST;
    end else if (wr_en && addr == MGR_ENABLE_OFS) begin
      enable_q <= wdata[1:0];
    end
  end

  // any nonzero write flushes
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_flush_q <= 1'b0;
      tx_flush_q <= 1'b0;
    end else begin
      rx_flush_q <= wr_en && addr == MGR_RXFLUSH_OFS && wdata != 8'h00;
      tx_flush_q <= wr_en && addr == MGR_TXFLUSH_OFS && wdata != 8'h00;
    end
  end

  // flush registers are write-only and read zero
  always_comb begin
    rdata = 8'h00;
    if (addr == MGR_ENABLE_OFS) begin
      rdata = {6'h00, enable_q};
    end
  end

  assign tx_fifo_en = enable_q[MGR_TX_BIT];
  assign rx_fifo_en = enable_q[MGR_RX_BIT];
  assign rx_flush = rx_flush_q;
  assign tx_flush = tx_flush_q;

  property p_rx_en_cause;
    @(posedge ref_clk) disable iff (!arst_n)
    $rose(rx_fifo_en) |-> $past(wr_en && addr == MGR_ENABLE_OFS && wdata[1]);
  endproperty
  a_rx_en_cause: assert property (p_rx_en_cause) else $error("rx enable rose without write");

  property p_tx_flush_cause;
    @(posedge ref_clk) disable iff (!arst_n)
    tx_flush |-> $past(wr_en && addr == MGR_TXFLUSH_OFS && wdata != 8'h00) ##1 !tx_flush;
  endproperty
  a_tx_flush_cause: assert property (p_tx_flush_cause) else $error("bad transmit flush pulse");

endmodule : queue_manager

//--- hw/ctl_request_engine.sv
// endpoint-zero control request engine for the serial bridge register blocks
// assumes the usb engine runs on ref_clk and hands over decoded setup fields
// What this block does
// - vendor type 0x40 code 0 writes value low byte to block/register, no data
// - vendor type 0xc0 code 1 returns length bytes from selected block/register
// - block 0 is serial configuration, block 4 is queue manager
// - block 0x65 accesses go out to the external eeprom port
// - block 0x66 holds wide receive, low latency and interrupt packet enables
// - internal registers reachable only through vendor read and write requests
// - queue switch offset 0x10: bit0 transmit queue, bit1 receive queue
// - nonzero write at 0x18 or 0x1c flushes receive or transmit queue
// - class type 0x21 code 32 takes seven bytes of line coding
// - class type 0xa1 code 33 returns the seven line coding bytes
// - class type 0x21 code 34 value field drives modem control lines
// - class type 0x21 code 35 sends break for value milliseconds
// - device status type 0x80 code 0 returns two bytes, wake and power
`timescale 1ns/1ps
module ctl_request_engine
  import ctl_req_pkg::*;
#(
  parameter int MS_CYCLES = BREAK_UNIT_CYCLES
)
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic setup_valid,
  input wire logic [7:0] setup_type,
  input wire logic [7:0] setup_req,
  input wire logic [15:0] setup_value,
  input wire logic [15:0] setup_index,
  input wire logic [15:0] setup_length,
  input wire logic out_valid,
  input wire logic [7:0] out_data,
  input wire logic in_ready,
  output logic in_valid,
  output logic [7:0] in_data,
  output logic ctl_ack,
  output logic ctl_stall,
  output logic ee_req,
  output logic ee_write,
  output logic [7:0] ee_addr,
  output logic [7:0] ee_wdata,
  input wire logic ee_done,
  input wire logic [7:0] ee_rdata,
  input wire logic remote_wake_en,
  input wire logic self_powered,
  output logic tx_fifo_en,
  output logic rx_fifo_en,
  output logic rx_flush,
  output logic tx_flush,
  output logic uart_tx_en,
  output logic uart_rx_en,
  output logic [31:0] baud_rate,
  output logic [7:0] stop_bits,
  output logic [7:0] parity,
  output logic [7:0] data_bits,
  output logic dtr,
  output logic rts,
  output logic break_active,
  output logic wide_rx_en,
  output logic low_latency_en,
  output logic custom_int_en
);

  localparam int MSW = $clog2(MS_CYCLES);

  generate
    if (MS_CYCLES < 2) begin : g_bad_ms
      $error("MS_CYCLES must be at least 2");
    end
  endgenerate

  ctl_state_t state_q;
  in_src_t src_q;
  logic [7:0] blk_q;
  logic [7:0] addr_q;
  logic [15:0] rem_q;
  logic [2:0] cnt_q;
  logic [7:0] in_data_q;
  logic ack_q;
  logic stall_q;
  logic ee_req_q;
  logic ee_write_q;
  logic [7:0] ee_addr_q;
  logic [7:0] ee_wdata_q;
  logic [7:0] uart_regs_q [UART_REG_COUNT];
  logic [7:0] line_q [LINE_BYTES];
  logic wide_q;
  logic lowlat_q;
  logic intpkt_q;
  logic dtr_q;
  logic rts_q;
  logic break_q;
  logic brk_forever_q;
  logic [15:0] brk_left_q;
  logic [MSW-1:0] ms_cnt_q;
  logic ms_tick;
  logic take;
  logic is_wr;
  logic is_rd;
  logic is_setline;
  logic is_getline;
  logic is_ctrl;
  logic is_brk;
  logic is_stat;
  logic supported;
  logic reg_wr;
  logic [7:0] setup_blk;
  logic [7:0] setup_reg;
  logic [7:0] mgr_addr;
  logic [7:0] mgr_rdata;
  logic [7:0] fetch_byte;

  // blocks that answer register requests
  function automatic logic blk_known(input logic [7:0] blk);
    blk_known = blk == BLK_UART || blk == BLK_MGR || blk == BLK_EEPROM
      || blk == BLK_CUSTOM;
  endfunction : blk_known

  assign setup_reg = setup_index[7:0];
  assign setup_blk = setup_index[15:8];
  assign take = setup_valid && state_q == ST_IDLE;

  // request decode; registers have no other access path
  always_comb begin
    is_wr = setup_type == RT_VENDOR_OUT && setup_req == REQ_SET_REG
      && setup_length == 16'h0000;
    is_rd = setup_type == RT_VENDOR_IN && setup_req == REQ_GET_REG;
    is_setline = setup_type == RT_CLASS_OUT && setup_req == REQ_SET_LINE
      && setup_length == LINE_CODING_LEN;
    is_getline = setup_type == RT_CLASS_IN && setup_req == REQ_GET_LINE;
    is_ctrl = setup_type == RT_CLASS_OUT && setup_req == REQ_SET_CTRL
      && setup_length == 16'h0000;
    is_brk = setup_type == RT_CLASS_OUT && setup_req == REQ_BREAK
      && setup_length == 16'h0000;
    is_stat = setup_type == RT_DEV_IN && setup_req == REQ_GET_STATUS
      && setup_index == 16'h0000 && setup_value == 16'h0000;
    supported = ((is_wr || is_rd) && blk_known(setup_blk)) || is_setline || is_getline
      || is_ctrl || is_brk || is_stat;
    reg_wr = take && is_wr && blk_known(setup_blk) && setup_blk != BLK_EEPROM;
  end

  assign mgr_addr = reg_wr ? setup_reg : addr_q;

  queue_manager u_queue_manager (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .wr_en(reg_wr && setup_blk == BLK_MGR),
    .addr(mgr_addr),
    .wdata(setup_value[7:0]),
    .rdata(mgr_rdata),
    .tx_fifo_en(tx_fifo_en),
    .rx_fifo_en(rx_fifo_en),
    .rx_flush(rx_flush),
    .tx_flush(tx_flush)
  );

  // byte for the current read position
  always_comb begin
    fetch_byte = 8'h00;
    case (src_q)
      SRC_STAT: if (addr_q == 8'h00) fetch_byte = {6'h00, remote_wake_en, self_powered};
      SRC_LINE: if (addr_q < 8'(LINE_BYTES)) fetch_byte = line_q[addr_q[2:0]];
      default: begin
        if (blk_q == BLK_UART && addr_q < 8'(UART_REG_COUNT)) begin
          fetch_byte = uart_regs_q[addr_q[4:0]];
        end else if (blk_q == BLK_MGR) begin
          fetch_byte = mgr_rdata;
        end else if (blk_q == BLK_CUSTOM) begin
          if (addr_q == CUST_WIDE_OFS) fetch_byte = {7'h00, wide_q};
          if (addr_q == CUST_LOWLAT_OFS) fetch_byte = {7'h00, lowlat_q};
          if (addr_q == CUST_INTPKT_OFS) fetch_byte = {7'h00, intpkt_q};
        end
      end
    endcase
  end

  // control transfer sequencing
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_IDLE;
      src_q <= SRC_REG;
      blk_q <= 8'h00;
      addr_q <= 8'h00;
      rem_q <= 16'h0000;
      cnt_q <= 3'h0;
      in_data_q <= 8'h00;
      ack_q <= 1'b0;
      stall_q <= 1'b0;
      ee_req_q <= 1'b0;
      ee_write_q <= 1'b0;
      ee_addr_q <= 8'h00;
      ee_wdata_q <= 8'h00;
    end else begin
      ack_q <= 1'b0;
      stall_q <= 1'b0;
      ee_req_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (take) begin
            blk_q <= setup_blk;
            addr_q <= setup_reg;
            rem_q <= setup_length;
            src_q <= SRC_REG;
            cnt_q <= 3'h0;
            if (!supported) begin
              stall_q <= 1'b1;
            end else if (is_wr && setup_blk == BLK_EEPROM) begin
              ee_req_q <= 1'b1;
              ee_write_q <= 1'b1;
              ee_addr_q <= setup_reg;
              ee_wdata_q <= setup_value[7:0];
              state_q <= ST_EE_WRITE;
            end else if (is_wr || is_ctrl || is_brk) begin
              ack_q <= 1'b1;
            end else if (is_setline) begin
              state_q <= ST_LINE_OUT;
            end else begin
              if (is_getline) begin
                src_q <= SRC_LINE;
                addr_q <= 8'h00;
                rem_q <= setup_length > LINE_CODING_LEN ? LINE_CODING_LEN : setup_length;
              end else if (is_stat) begin
                src_q <= SRC_STAT;
                addr_q <= 8'h00;
                rem_q <= setup_length > STATUS_LEN ? STATUS_LEN : setup_length;
              end
              if (setup_length == 16'h0000) begin
                ack_q <= 1'b1;
              end else begin
                state_q <= ST_FETCH;
              end
            end
          end
        end
        ST_LINE_OUT: begin
          if (out_valid) begin
            cnt_q <= cnt_q + 3'h1;
            if (cnt_q == 3'(LINE_BYTES - 1)) begin
              ack_q <= 1'b1;
              state_q <= ST_IDLE;
            end
          end
        end
        ST_FETCH: begin
          if (src_q == SRC_REG && blk_q == BLK_EEPROM) begin
            ee_req_q <= 1'b1;
            ee_write_q <= 1'b0;
            ee_addr_q <= addr_q;
            state_q <= ST_EE_WAIT;
          end else begin
            in_data_q <= fetch_byte;
            state_q <= ST_SEND;
          end
        end
        ST_EE_WAIT: begin
          if (ee_done) begin
            in_data_q <= ee_rdata;
            state_q <= ST_SEND;
          end
        end
        ST_EE_WRITE: begin
          if (ee_done) begin
            ack_q <= 1'b1;
            state_q <= ST_IDLE;
          end
        end
        ST_SEND: begin
          if (in_ready) begin
            if (rem_q == 16'h0001) begin
              ack_q <= 1'b1;
              state_q <= ST_IDLE;
            end else begin
              rem_q <= rem_q - 16'h0001;
              addr_q <= addr_q + 8'h01;
              state_q <= ST_FETCH;
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // serial configuration block
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < UART_REG_COUNT; i++) uart_regs_q[i] <= UART_REG_RST;
    end else if (reg_wr && setup_blk == BLK_UART && setup_reg < 8'(UART_REG_COUNT)) begin
      uart_regs_q[setup_reg[4:0]] <= setup_value[7:0];
    end
  end

  // line coding storage
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < LINE_BYTES; i++) line_q[i] <= LINE_CODING_RST[8*i +: 8];
    end else if (state_q == ST_LINE_OUT && out_valid) begin
      line_q[cnt_q] <= out_data;
    end
  end

  // vendor extension enables
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wide_q <= 1'b0;
      lowlat_q <= 1'b0;
      intpkt_q <= 1'b0;
    end else if (reg_wr && setup_blk == BLK_CUSTOM) begin
      if (setup_reg == CUST_WIDE_OFS) wide_q <= setup_value[0];
      if (setup_reg == CUST_LOWLAT_OFS) lowlat_q <= setup_value[0];
      if (setup_reg == CUST_INTPKT_OFS) intpkt_q <= setup_value[0];
    end
  end

  // modem control lines
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      dtr_q <= 1'b0;
      rts_q <= 1'b0;
    end else if (take && is_ctrl) begin
      dtr_q <= setup_value[CTRL_DTR_BIT];
      rts_q <= setup_value[CTRL_RTS_BIT];
    end
  end

  assign ms_tick = ms_cnt_q == MSW'(MS_CYCLES - 1);

  // break timer, millisecond steps, 0xffff holds until a zero break
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      break_q <= 1'b0;
      brk_forever_q <= 1'b0;
      brk_left_q <= 16'h0000;
      ms_cnt_q <= '0;
    end else if (take && is_brk) begin
      break_q <= setup_value != 16'h0000;
      brk_forever_q <= setup_value == BREAK_FOREVER;
      brk_left_q <= setup_value;
      ms_cnt_q <= '0;
    end else if (break_q && !brk_forever_q) begin
      ms_cnt_q <= ms_tick ? '0 : ms_cnt_q + MSW'(1);
      if (ms_tick) begin
        brk_left_q <= brk_left_q - 16'h0001;
        if (brk_left_q == 16'h0001) break_q <= 1'b0;
      end
    end
  end

  assign in_valid = state_q == ST_SEND;
  assign in_data = in_data_q;
  assign ctl_ack = ack_q;
  assign ctl_stall = stall_q;
  assign ee_req = ee_req_q;
  assign ee_write = ee_write_q;
  assign ee_addr = ee_addr_q;
  assign ee_wdata = ee_wdata_q;
  assign uart_tx_en = uart_regs_q[UART_ENABLE_OFS[4:0]][0];
  assign uart_rx_en = uart_regs_q[UART_ENABLE_OFS[4:0]][1];
  assign baud_rate = {line_q[3], line_q[2], line_q[1], line_q[0]};
  assign stop_bits = line_q[4];
  assign parity = line_q[5];
  assign data_bits = line_q[6];
  assign dtr = dtr_q;
  assign rts = rts_q;
  assign break_active = break_q;
  assign wide_rx_en = wide_q;
  assign low_latency_en = lowlat_q;
  assign custom_int_en = intpkt_q;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  property p_write_acked;
    take && is_wr && (setup_blk == BLK_UART || setup_blk == BLK_CUSTOM) |=> ctl_ack && !in_valid;
  endproperty
  a_write_acked: assert property (p_write_acked) else $error("register write not acked");

  property p_unsupported_stall;
    take && !supported |=> ctl_stall && !ctl_ack && state_q == ST_IDLE;
  endproperty
  a_unsupported_stall: assert property (p_unsupported_stall) else $error("no stall");

  property p_queue_enable;
    take && is_wr && setup_blk == BLK_MGR && setup_reg == MGR_ENABLE_OFS
      |=> tx_fifo_en == $past(setup_value[0]) && rx_fifo_en == $past(setup_value[1]);
  endproperty
  a_queue_enable: assert property (p_queue_enable) else $error("queue switch not updated");

  property p_rx_flush;
    take && is_wr && setup_blk == BLK_MGR && setup_reg == MGR_RXFLUSH_OFS
      |=> rx_flush == ($past(setup_value[7:0]) != 8'h00);
  endproperty
  a_rx_flush: assert property (p_rx_flush) else $error("receive flush wrong");

  property p_eeprom_route;
    take && is_wr && setup_blk == BLK_EEPROM |=> ee_req && ee_write && !ctl_ack;
  endproperty
  a_eeprom_route: assert property (p_eeprom_route) else $error("eeprom write not routed");

  property p_modem_lines;
    take && is_ctrl |=> dtr == $past(setup_value[0]) && rts == $past(setup_value[1]);
  endproperty
  a_modem_lines: assert property (p_modem_lines) else $error("modem lines not driven");

  property p_break_start;
    take && is_brk && setup_value != 16'h0000 |=> break_active [*2];
  endproperty
  a_break_start: assert property (p_break_start) else $error("break not started");

  property p_status_byte;
    take && is_stat && setup_length != 16'h0000 |-> ##2 in_valid
      && in_data == {6'h00, $past(remote_wake_en), $past(self_powered)};
  endproperty
  a_status_byte: assert property (p_status_byte) else $error("status byte wrong");

  property p_line_read;
    take && is_getline && setup_length != 16'h0000 |-> ##2 in_valid && in_data == line_q[0];
  endproperty
  a_line_read: assert property (p_line_read) else $error("line coding read wrong");

  property p_setline_ack;
    state_q == ST_LINE_OUT && out_valid && cnt_q == 3'h6 |=> ctl_ack && state_q == ST_IDLE;
  endproperty
  a_setline_ack: assert property (p_setline_ack) else $error("line coding not acked");

endmodule : ctl_request_engine

//--- verification/usb_host_model.sv
// host controller model: issues control transfers on endpoint zero, collects data-in bytes
// assumes the engine samples every input on the rising edge of ref_clk
`timescale 1ns/1ps
module usb_host_model (
  input wire logic ref_clk,
  input wire logic slow,
  output logic setup_valid,
  output logic [7:0] setup_type,
  output logic [7:0] setup_req,
  output logic [15:0] setup_value,
  output logic [15:0] setup_index,
  output logic [15:0] setup_length,
  output logic out_valid,
  output logic [7:0] out_data,
  output logic in_ready,
  input wire logic in_valid,
  input wire logic [7:0] in_data,
  input wire logic ctl_ack,
  input wire logic ctl_stall
);
  initial begin
    setup_valid = 1'b0;
    {setup_type, setup_req, setup_value, setup_index, setup_length} = '0;
    out_valid = 1'b0;
    out_data = 8'h00;
    in_ready = 1'b0;
  end

  // slow mode stalls the data-in stage every other cycle
  always @(posedge ref_clk) begin
    in_ready <= slow ? ~in_ready : 1'b1;
  end

  task automatic xfer(input logic [63:0] s, input logic [55:0] d, output logic [55:0] got,
                      output int n, output logic st);
    int k;
    got = '0;
    n = 0;
    @(posedge ref_clk);
    setup_valid <= 1'b1;
    {setup_type, setup_req, setup_value, setup_index, setup_length} <= s;
    @(posedge ref_clk);
    setup_valid <= 1'b0;
    {setup_type, setup_req, setup_value, setup_index, setup_length} <= ~s;
    if (s[63:48] == 16'h2120 && s[15:0] == 16'h0007) begin
      for (k = 0; k < 7; k++) begin
        out_valid <= 1'b1;
        out_data <= d[8*k +: 8];
        @(posedge ref_clk);
      end
      out_valid <= 1'b0;
      out_data <= ~out_data;
    end
    for (k = 0; k < 300; k++) begin
      if (in_valid === 1'b1 && in_ready === 1'b1) begin
        got[8*n +: 8] = in_data;
        n++;
      end
      if (ctl_ack === 1'b1 || ctl_stall === 1'b1) break;
      @(posedge ref_clk);
    end
    st = ctl_stall;
    if (k == 300) n = -1;
  endtask : xfer
endmodule : usb_host_model

//--- verification/tb_ctl_request_engine.sv
// self-checking bench for the endpoint-zero request engine
// assumes the host model on the usb side and a small eeprom responder in here
`timescale 1ns/1ps
module tb_ctl_request_engine;
  import ctl_req_pkg::*;
  localparam int MS = 8;
  typedef struct packed {logic [63:0] s; logic [55:0] d; logic st;} row_t;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic slow = 1'b0;
  logic wake = 1'b1;
  logic selfp = 1'b0;
  logic setup_valid, out_valid, in_ready, in_valid, ctl_ack, ctl_stall, ee_req, ee_write, st;
  logic [7:0] setup_type, setup_req, out_data, in_data, ee_addr, ee_wdata;
  logic [7:0] stop_bits, parity, data_bits;
  logic [15:0] setup_value, setup_index, setup_length;
  logic [15:0] ee_last = 16'h0000;
  logic ee_done = 1'b0;
  logic [7:0] ee_rdata = 8'h00;
  logic [2:0] ee_cnt = 3'd0;
  logic tx_fifo_en, rx_fifo_en, rx_flush, tx_flush, uart_tx_en, uart_rx_en, dtr, rts;
  logic break_active, wide_rx_en, low_latency_en, custom_int_en;
  logic [31:0] baud_rate;
  logic [55:0] got, mask;
  int n_errors = 0, n_compared = 0, n_rx = 0, n_tx = 0, n_brk = 0, cyc = 0, n, en;
  row_t rows [27] = '{
    '{64'hc0_01_0000_0410_0001, 56'h00, 1'b0},
    '{64'h40_00_0001_0410_0000, 56'h00, 1'b0},
    '{64'h40_00_0003_0003_0000, 56'h00, 1'b0},
    '{64'h40_00_0003_0410_0000, 56'h00, 1'b0},
    '{64'h40_00_00ff_0410_0000, 56'h00, 1'b0},
    '{64'hc0_01_0000_0410_0001, 56'h03, 1'b0},
    '{64'h40_00_00a5_0004_0000, 56'h00, 1'b0},
    '{64'h40_00_005a_0005_0000, 56'h00, 1'b0},
    '{64'hc0_01_0000_0003_0003, 56'h5a_a5_03, 1'b0},
    '{64'h40_00_0001_6601_0000, 56'h00, 1'b0},
    '{64'h40_00_0001_6602_0000, 56'h00, 1'b0},
    '{64'hc0_01_0000_6600_0003, 56'h01_01_00, 1'b0},
    '{64'h40_00_0001_6600_0000, 56'h00, 1'b0},
    '{64'h21_20_0000_0000_0007, 56'h07_02_00_00_00_25_80, 1'b0},
    '{64'ha1_21_0000_0000_0007, 56'h07_02_00_00_00_25_80, 1'b0},
    '{64'h21_22_0003_0000_0000, 56'h00, 1'b0},
    '{64'h80_00_0000_0000_0002, 56'h00_02, 1'b0},
    '{64'hc0_01_0000_6507_0001, 56'h5d, 1'b0},
    '{64'h40_00_0033_6510_0000, 56'h00, 1'b0},
    '{64'h40_00_0000_0418_0000, 56'h00, 1'b0},
    '{64'h41_00_0000_0000_0000, 56'h00, 1'b1},
    '{64'h40_00_0001_0500_0000, 56'h00, 1'b1},
    '{64'hc0_02_0000_0000_0001, 56'h00, 1'b1},
    '{64'h40_00_0001_0003_0001, 56'h00, 1'b1},
    '{64'h21_20_0000_0000_0006, 56'h00, 1'b1},
    '{64'h80_00_0001_0000_0002, 56'h00, 1'b1},
    '{64'h21_23_0000_0000_0000, 56'h00, 1'b0}
  };

  always #2.5 ref_clk = ~ref_clk;

  usb_host_model i_usb_host_model (.ref_clk, .slow, .setup_valid, .setup_type, .setup_req,
    .setup_value, .setup_index, .setup_length, .out_valid, .out_data, .in_ready, .in_valid,
    .in_data, .ctl_ack, .ctl_stall);

  ctl_request_engine #(.MS_CYCLES(MS)) i_ctl_request_engine (.ref_clk, .arst_n, .setup_valid,
    .setup_type, .setup_req, .setup_value, .setup_index, .setup_length, .out_valid, .out_data,
    .in_ready, .in_valid, .in_data, .ctl_ack, .ctl_stall, .ee_req, .ee_write, .ee_addr,
    .ee_wdata, .ee_done, .ee_rdata, .remote_wake_en(wake), .self_powered(selfp), .tx_fifo_en,
    .rx_fifo_en, .rx_flush, .tx_flush, .uart_tx_en, .uart_rx_en, .baud_rate, .stop_bits,
    .parity, .data_bits, .dtr, .rts, .break_active, .wide_rx_en, .low_latency_en,
    .custom_int_en);

  // eeprom responder: done three cycles after a request, read data is address xor 0x5a
  always @(posedge ref_clk) begin
    ee_done <= 1'b0;
    ee_rdata <= ~ee_rdata;
    if (ee_req === 1'b1) ee_cnt <= 3'd3;
    else if (ee_cnt != 3'd0) ee_cnt <= ee_cnt - 3'd1;
    if (ee_cnt == 3'd1) begin
      ee_done <= 1'b1;
      ee_rdata <= ee_addr ^ 8'h5a;
      if (ee_write === 1'b1) ee_last <= {ee_addr, ee_wdata};
    end
  end

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (rx_flush === 1'b1) n_rx <= n_rx + 1;
    if (tx_flush === 1'b1) n_tx <= n_tx + 1;
    if (break_active === 1'b1) n_brk <= n_brk + 1;
    if (cyc == 5000) begin
      n_errors++;
      stop_test();
    end
  end

  task automatic check(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : check

  task automatic stop_test();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test

  task automatic reset_check();
    arst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    check("reset enables", 9'h0, {tx_fifo_en, rx_fifo_en, uart_tx_en, uart_rx_en, dtr, rts,
      wide_rx_en, low_latency_en, custom_int_en});
    arst_n <= 1'b1;
    @(posedge ref_clk);
    check("reset line", {32'd115200, 24'h8}, {baud_rate, stop_bits, parity, data_bits});
  endtask : reset_check

  initial begin
    reset_check();
    for (int i = 0; i < 27; i++) begin
      slow <= i[0];
      i_usb_host_model.xfer(rows[i].s, rows[i].d, got, n, st);
      en = (rows[i].s[63] && !rows[i].st) ? int'(rows[i].s[15:0]) : 0;
      mask = (56'h1 << (8 * en)) - 56'h1;
      check("stall", 64'(rows[i].st), 64'(st));
      check("count", 64'(en), 64'(n));
      check("in data", 64'(rows[i].d & mask), 64'(got));
    end
    check("enables", 9'b111111111, {tx_fifo_en, rx_fifo_en, uart_tx_en, uart_rx_en, dtr, rts,
      wide_rx_en, low_latency_en, custom_int_en});
    check("line", {32'h2580, 24'h000207}, {baud_rate, stop_bits, parity, data_bits});
    check("eeprom write", 16'h1033, ee_last);
    check("zero break", 0, 64'(n_brk));
    i_usb_host_model.xfer(64'h40_00_0001_0418_0000, 56'h0, got, n, st);
    i_usb_host_model.xfer(64'h40_00_0080_041c_0000, 56'h0, got, n, st);
    i_usb_host_model.xfer(64'h21_23_0002_0000_0000, 56'h0, got, n, st);
    repeat (30) @(posedge ref_clk);
    check("flushes", 64'h11, 64'(n_rx * 16 + n_tx));
    check("break length", 64'(2 * MS), 64'(n_brk));
    i_usb_host_model.xfer(64'h21_23_ffff_0000_0000, 56'h0, got, n, st);
    repeat (3 * MS) @(posedge ref_clk);
    check("break hold", 1, 64'(break_active));
    i_usb_host_model.xfer(64'h21_23_0000_0000_0000, 56'h0, got, n, st);
    check("break stop", 0, 64'(break_active));
    wake <= 1'b0;
    selfp <= 1'b1;
    i_usb_host_model.xfer(64'h80_00_0000_0000_0002, 56'h0, got, n, st);
    check("status count", 2, 64'(n));
    check("status", 16'h0001, got);
    reset_check();
    stop_test();
  end
endmodule : tb_ctl_request_engine
